// *** hw/micr_pkg.sv ***
// Constants, register map and types of the microphone I2C register block
package micr_pkg;

    // Bus address: the low bit follows the channel-select pin
    localparam logic [6:0] MICR_DEV_ADDR_BASE = 7'h60;

    // Register indices
    localparam logic [7:0] MICR_REG_CTRL   = 8'h00;
    localparam logic [7:0] MICR_REG_GAIN   = 8'h01;
    localparam logic [7:0] MICR_REG_FILTER = 8'h02;
    localparam logic [7:0] MICR_REG_FLOOR  = 8'h03;
    localparam logic [7:0] MICR_REG_CEIL   = 8'h04;
    localparam logic [7:0] MICR_REG_MARGIN = 8'h05;

    // Field positions
    localparam int MICR_CTRL_EN_BIT    = 0;
    localparam int MICR_CTRL_DLY_LSB   = 1;
    localparam int MICR_CTRL_CLEAR_BIT = 4;
    localparam int MICR_FILT_LPF_LSB   = 0;
    localparam int MICR_FILT_HPF_LSB   = 2;
    localparam int MICR_GAIN_LSB       = 0;
    localparam int MICR_FAST_LSB       = 5;
    localparam int MICR_RMS_BIT        = 5;
    localparam int MICR_MARGIN_LSB     = 0;

    // Values after reset
    localparam logic       MICR_RST_WDT_EN  = 1'h0;
    localparam logic [1:0] MICR_RST_BUS_TIMEOUT_SELECT = 2'h0;
    localparam logic [4:0] MICR_RST_GAIN    = 5'h10;
    localparam logic [1:0] MICR_RST_HPF     = 2'h3;
    localparam logic [1:0] MICR_RST_LPF     = 2'h0;
    localparam logic [1:0] MICR_RST_FAST    = 2'h2;
    localparam logic [4:0] MICR_RST_FLOOR   = 5'h00;
    localparam logic       MICR_RST_RMS     = 1'h0;
    localparam logic [4:0] MICR_RST_CEIL    = 5'h1B;
    localparam logic [2:0] MICR_RST_MARGIN  = 3'h7;

    // Watchdog timebase: shortest timeout, longer ones are doublings
    localparam int MICR_CLK_HZ       = 10_000_000;
    localparam int MICR_WDT_BASE_MS  = 8;
    localparam int MICR_WDT_BASE_CYC = (MICR_WDT_BASE_MS * MICR_CLK_HZ) / 1000;
    localparam int MICR_WDT_W        = 21;

    // Configuration presented to the acoustic loop
    typedef struct packed {
        logic       bus_timeout_enable;
        logic [1:0] bus_timeout_select;
        logic [1:0] detect_highpass_corner;
        logic [1:0] detect_lowpass_corner;
        logic [1:0] fast_adapt_count;
        logic [4:0] gain_floor;
        logic       rms_rate;
        logic [4:0] gain_ceiling;
        logic [2:0] trigger_margin;
    } micr_cfg_t;

    typedef enum logic [3:0] {
        MICR_IDLE     = 4'h0,
        MICR_ADDR     = 4'h1,
        MICR_ADDR_ACK = 4'h2,
        MICR_REG      = 4'h3,
        MICR_REG_ACK  = 4'h4,
        MICR_WR       = 4'h5,
        MICR_WR_ACK   = 4'h6,
        MICR_RD       = 4'h7,
        MICR_RD_ACK   = 4'h8
    } micr_state_t;

endpackage

// *** hw/micr_regs.sv ***
// I2C slave and configuration registers of the microphone
`timescale 1ns/10ps

// What this block does
// - Answer at bus address 0x60 with channel pin low, 0x61 with it high.
// - All registers reset to documented defaults, readable over the bus.
// - Writing one to wake-clear drops the wake flag, unless a trigger arrives in that cycle, and re-arms detection.
// - Watchdog counter cleared and stopped at each transaction end.
// - Watchdog expiry resets only the serial interface, not registers.
// - Timeout select codes 00..11 give 8, 16, 32, 64 ms.
// - Watchdog disabled never resets the interface.
// - Ambient gain register is read-only and shows the loop gain.
// - Gain code 0 means 91.5 dB SPL, down 1.5 dB per step to 45.
// - Reading the gain register leaves operation undisturbed.
// - Low-pass corner bits 1:0 select 2, 4, 6 or 8 kHz.
// - High-pass corner codes select 200, 300, 400 or 800 Hz.
// - High-pass corner occupies filter register bits 3:2.
// - Loop gain is held between programmed floor and ceiling, or at the ceiling when the floor is above it.
// - Three-bit trigger margin, 6 dB at 001 to 18 dB at 111.
// - Fast-adapt count: 00 off, else 2, 4, 6 same-direction trips.
module micr_regs
    import micr_pkg::*;
#(
    parameter int WDT_BASE_CYC = MICR_WDT_BASE_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       channel_select_pin,
    input  wire logic [4:0] loop_gain_request,
    input  wire logic       acoustic_trigger,
    output logic            wake_flag,
    output logic            trigger_rearm,
    output logic [4:0]      ambient_gain_code,
    output micr_cfg_t       cfg
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: stage 1 is read only by stage 2
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [1:0] prev_q;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sync1_q <= 3'h7;
            sync2_q <= 3'h7;
            prev_q  <= 2'h3;
        end else begin
            sync1_q <= {channel_select_pin, scl_in, sda_in};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q[1:0];
        end
    end

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [6:0] my_addr;

    // Edges from stage 2 against its one-cycle-older copy
    assign scl_s     = sync2_q[1];
    assign sda_s     = sync2_q[0];
    assign scl_rise  = scl_s & ~prev_q[1];
    assign scl_fall  = ~scl_s & prev_q[1];
    assign bus_start = scl_s & prev_q[1] & ~sda_s & prev_q[0];
    assign bus_stop  = scl_s & prev_q[1] & sda_s & ~prev_q[0];
    assign my_addr   = {MICR_DEV_ADDR_BASE[6:1], sync2_q[2]};

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    micr_cfg_t  cfg_q;
    micr_cfg_t  cfg_d;
    logic [4:0] gain_q;
    logic [4:0] gain_d;
    logic       wake_q;
    logic       wake_d;
    logic       rearm_q;
    logic       rearm_d;
    logic       wr_en;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;
    logic [7:0] rd_idx;
    logic [7:0] rd_data;

    // Register read mux; nothing here has side effects, so reads never upset the loop
    always_comb begin
        rd_data = 8'h00;
        case (rd_idx)
            MICR_REG_CTRL: begin
                rd_data[MICR_CTRL_EN_BIT]       = cfg_q.bus_timeout_enable;
                rd_data[MICR_CTRL_DLY_LSB +: 2] = cfg_q.bus_timeout_select;
            end
            MICR_REG_GAIN:   rd_data[MICR_GAIN_LSB +: 5] = gain_q;
            MICR_REG_FILTER: begin
                rd_data[MICR_FILT_LPF_LSB +: 2] = cfg_q.detect_lowpass_corner;
                rd_data[MICR_FILT_HPF_LSB +: 2] = cfg_q.detect_highpass_corner;
            end
            MICR_REG_FLOOR: begin
                rd_data[MICR_GAIN_LSB +: 5] = cfg_q.gain_floor;
                rd_data[MICR_FAST_LSB +: 2] = cfg_q.fast_adapt_count;
            end
            MICR_REG_CEIL: begin
                rd_data[MICR_GAIN_LSB +: 5] = cfg_q.gain_ceiling;
                rd_data[MICR_RMS_BIT]       = cfg_q.rms_rate;
            end
            MICR_REG_MARGIN: rd_data[MICR_MARGIN_LSB +: 3] = cfg_q.trigger_margin;
            default:         rd_data = 8'h00;
        endcase
    end

    // Writes, gain tracking and wake flag
    always_comb begin
        cfg_d   = cfg_q;
        rearm_d = 1'b0;
        if (wr_en) begin
            case (wr_idx)
                MICR_REG_CTRL: begin
                    cfg_d.bus_timeout_enable = wr_data[MICR_CTRL_EN_BIT];
                    cfg_d.bus_timeout_select = wr_data[MICR_CTRL_DLY_LSB +: 2];
                    rearm_d = wr_data[MICR_CTRL_CLEAR_BIT];
                end
                MICR_REG_FILTER: begin
                    cfg_d.detect_lowpass_corner  = wr_data[MICR_FILT_LPF_LSB +: 2];
                    cfg_d.detect_highpass_corner = wr_data[MICR_FILT_HPF_LSB +: 2];
                end
                MICR_REG_FLOOR: begin
                    cfg_d.gain_floor       = wr_data[MICR_GAIN_LSB +: 5];
                    cfg_d.fast_adapt_count = wr_data[MICR_FAST_LSB +: 2];
                end
                MICR_REG_CEIL: begin
                    cfg_d.gain_ceiling = wr_data[MICR_GAIN_LSB +: 5];
                    cfg_d.rms_rate     = wr_data[MICR_RMS_BIT];
                end
                MICR_REG_MARGIN: cfg_d.trigger_margin = wr_data[MICR_MARGIN_LSB +: 3];
                default: cfg_d = cfg_q;
            endcase
        end
        // Floor first, ceiling last: a crossed setting resolves to the ceiling
        gain_d = loop_gain_request;
        if (gain_d < cfg_q.gain_floor) begin
            gain_d = cfg_q.gain_floor;
        end
        if (gain_d > cfg_q.gain_ceiling) begin
            gain_d = cfg_q.gain_ceiling;
        end
        // A trigger in the clearing cycle wins so no event is lost
        wake_d = wake_q;
        if (rearm_d) begin
            wake_d = 1'b0;
        end
        if (acoustic_trigger) begin
            wake_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cfg_q.bus_timeout_enable     <= MICR_RST_WDT_EN;
            cfg_q.bus_timeout_select     <= MICR_RST_BUS_TIMEOUT_SELECT;
            cfg_q.detect_highpass_corner <= MICR_RST_HPF;
            cfg_q.detect_lowpass_corner  <= MICR_RST_LPF;
            cfg_q.fast_adapt_count       <= MICR_RST_FAST;
            cfg_q.gain_floor             <= MICR_RST_FLOOR;
            cfg_q.rms_rate               <= MICR_RST_RMS;
            cfg_q.gain_ceiling           <= MICR_RST_CEIL;
            cfg_q.trigger_margin         <= MICR_RST_MARGIN;
            gain_q                       <= MICR_RST_GAIN;
            wake_q                       <= 1'b0;
            rearm_q                      <= 1'b0;
        end else begin
            cfg_q   <= cfg_d;
            gain_q  <= gain_d;
            wake_q  <= wake_d;
            rearm_q <= rearm_d;
        end
    end

    assign cfg               = cfg_q;
    assign ambient_gain_code = gain_q;
    assign wake_flag         = wake_q;
    assign trigger_rearm     = rearm_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus watchdog: runs only inside a transaction
    logic                  busy_q;
    logic                  busy_d;
    logic [MICR_WDT_W-1:0] wdt_q;
    logic [MICR_WDT_W-1:0] wdt_d;
    logic [MICR_WDT_W-1:0] wdt_limit;
    logic                  bus_rst;

    assign wdt_limit = MICR_WDT_W'(WDT_BASE_CYC) << cfg_q.bus_timeout_select;
    assign bus_rst   = cfg_q.bus_timeout_enable & busy_q & (wdt_q > wdt_limit);

    always_comb begin
        busy_d = busy_q;
        wdt_d  = wdt_q;
        if (bus_start) begin
            busy_d = 1'b1;
        end
        if (bus_stop || bus_rst) begin
            busy_d = 1'b0;
        end
        if (!busy_q || bus_stop || !cfg_q.bus_timeout_enable) begin
            wdt_d = '0;
        end else if (wdt_q <= wdt_limit) begin
            wdt_d = wdt_q + MICR_WDT_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            wdt_q  <= '0;
        end else begin
            busy_q <= busy_d;
            wdt_q  <= wdt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial engine: sample on SCL rise, change SDA on SCL fall
    micr_state_t st_q;
    micr_state_t st_d;
    logic [3:0]  bit_q;
    logic [3:0]  bit_d;
    logic [7:0]  sh_q;
    logic [7:0]  sh_d;
    logic [7:0]  ptr_q;
    logic [7:0]  ptr_d;
    logic        rw_q;
    logic        rw_d;
    logic        drv_q;
    logic        drv_d;

    assign rd_idx  = ptr_q;
    assign wr_idx  = ptr_q;
    assign wr_data = sh_q;

    always_comb begin
        st_d  = st_q;
        bit_d = bit_q;
        sh_d  = sh_q;
        ptr_d = ptr_q;
        rw_d  = rw_q;
        drv_d = drv_q;
        wr_en = 1'b0;
        if (bus_rst || bus_stop) begin
            st_d  = MICR_IDLE;
            drv_d = 1'b0;
        end else if (bus_start) begin
            st_d  = MICR_ADDR;
            bit_d = 4'h0;
            drv_d = 1'b0;
        end else begin
            case (st_q)
                MICR_IDLE: st_d = MICR_IDLE;
                MICR_ADDR, MICR_REG, MICR_WR: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_s};
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        drv_d = 1'b1;
                        if (st_q == MICR_ADDR) begin
                            rw_d = sh_q[0];
                            if (sh_q[7:1] == my_addr) begin
                                st_d = MICR_ADDR_ACK;
                            end else begin
                                st_d  = MICR_IDLE;
                                drv_d = 1'b0;
                            end
                        end else if (st_q == MICR_REG) begin
                            ptr_d = sh_q;
                            st_d  = MICR_REG_ACK;
                        end else begin
                            wr_en = 1'b1;
                            ptr_d = ptr_q + 8'h01;
                            st_d  = MICR_WR_ACK;
                        end
                    end
                end
                MICR_ADDR_ACK, MICR_REG_ACK, MICR_WR_ACK: begin
                    if (scl_fall) begin
                        bit_d = 4'h0;
                        drv_d = 1'b0;
                        st_d  = (st_q == MICR_ADDR_ACK) ? MICR_REG : MICR_WR;
                        if (st_q == MICR_ADDR_ACK && rw_q) begin
                            sh_d  = rd_data;
                            drv_d = ~rd_data[7];
                            ptr_d = ptr_q + 8'h01;
                            st_d  = MICR_RD;
                        end
                    end
                end
                MICR_RD: begin
                    if (scl_rise) begin
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_q == 4'h8) begin
                            drv_d = 1'b0;
                            st_d  = MICR_RD_ACK;
                        end else begin
                            sh_d  = {sh_q[6:0], 1'b0};
                            drv_d = ~sh_q[6];
                        end
                    end
                end
                MICR_RD_ACK: begin
                    // A master NACK ends the read; wait in MICR_IDLE for STOP
                    if (scl_rise && sda_s) begin
                        st_d = MICR_IDLE;
                    end else if (scl_fall) begin
                        bit_d = 4'h0;
                        sh_d  = rd_data;
                        drv_d = ~rd_data[7];
                        ptr_d = ptr_q + 8'h01;
                        st_d  = MICR_RD;
                    end
                end
                default: st_d = MICR_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st_q  <= MICR_IDLE;
            bit_q <= 4'h0;
            sh_q  <= 8'h00;
            ptr_q <= 8'h00;
            rw_q  <= 1'b0;
            drv_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            bit_q <= bit_d;
            sh_q  <= sh_d;
            ptr_q <= ptr_d;
            rw_q  <= rw_d;
            drv_q <= drv_d;
        end
    end

    // Open drain: only ever pull low
    assign sda_out  = 1'b0;
    assign sda_oe_n = ~drv_q;

endmodule

// *** tb/micr_checker.sv ***
// Pin-level assertions for the microphone register block
`timescale 1ns/10ps
module micr_checker
    import micr_pkg::*;
#(
    parameter int WDT_BASE_CYC = MICR_WDT_BASE_CYC
) (
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic       channel_select_pin,
    input wire logic [4:0] loop_gain_request,
    input wire logic       acoustic_trigger,
    input wire logic       wake_flag,
    input wire logic       trigger_rearm,
    input wire logic [4:0] ambient_gain_code,
    input wire micr_cfg_t  cfg
);
    localparam micr_cfg_t RST_CFG = '{MICR_RST_WDT_EN, MICR_RST_BUS_TIMEOUT_SELECT, MICR_RST_HPF, MICR_RST_LPF,
        MICR_RST_FAST, MICR_RST_FLOOR, MICR_RST_RMS, MICR_RST_CEIL, MICR_RST_MARGIN};
    // Floor first, then ceiling, so a crossed pair settles on the ceiling
    function automatic logic [4:0] clampg(logic [4:0] r, logic [4:0] f, logic [4:0] c);
        logic [4:0] v;
        v = (r < f) ? f : r;
        return (v > c) ? c : v;
    endfunction
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////
    chk_reset_vals: assert property ($rose(reset_n) |-> sda_oe_n && !wake_flag && cfg == RST_CFG)
        else $error("outputs not at defaults after reset");
    chk_gain_clamp: assert property ($past(reset_n) && $stable(cfg) |-> ambient_gain_code ==
        clampg($past(loop_gain_request), $past(cfg.gain_floor), $past(cfg.gain_ceiling)))
        else $error("gain code outside floor and ceiling");
    chk_rearm_pulse: assert property (trigger_rearm |=> !trigger_rearm)
        else $error("re-arm longer than one cycle");
    // A trigger in the clearing cycle keeps the flag up, so only a clean clear is judged
    chk_wake_clear: assert property (trigger_rearm && !$past(acoustic_trigger) |-> !wake_flag)
        else $error("wake flag not cleared");
    chk_flag_fall: assert property ($fell(wake_flag) |-> trigger_rearm || $past(trigger_rearm))
        else $error("wake flag dropped without clear");
    chk_trig_sets: assert property (acoustic_trigger |=> wake_flag)
        else $error("trigger did not raise wake flag");
    chk_sda_scl_low: assert property (!$stable(sda_oe_n) |-> !scl_in && !$past(scl_in))
        else $error("data line moved while clock high");
    chk_cfg_stable: assert property ($changed(cfg) |-> !scl_in)
        else $error("configuration changed outside a write");
    // With settled limits in order, the readback never leaves the programmed window
    chk_gain_range: assert property (cfg.gain_floor <= cfg.gain_ceiling && $stable(cfg) |->
        ambient_gain_code >= cfg.gain_floor && ambient_gain_code <= cfg.gain_ceiling)
        else $error("gain code out of programmed range");
    cover property (trigger_rearm);
    cover property ($fell(sda_oe_n));
    cover property (acoustic_trigger ##1 wake_flag);
endmodule
////////////////////////////////////////////////////////////////
bind micr_regs micr_checker #(.WDT_BASE_CYC(WDT_BASE_CYC)) u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .channel_select_pin(channel_select_pin), .loop_gain_request(loop_gain_request),
    .acoustic_trigger(acoustic_trigger), .wake_flag(wake_flag), .trigger_rearm(trigger_rearm),
    .ambient_gain_code(ambient_gain_code), .cfg(cfg));

// *** tb/micr_host_model.sv ***
// Behavioural host I2C controller for the microphone register block
`timescale 1ns/10ps
module micr_host_model (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    // Idle bus: SCL driven high, SDA left to the pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Transfers are only issued while the audio path is quiet
    task automatic start;
        sda_low = 1'b0;
        #200 scl = 1'b1;
        #300 sda_low = 1'b1;
        #300 scl = 1'b0;
        #200;
    endtask
    task automatic stop;
        sda_low = 1'b1;
        #200 scl = 1'b1;
        #300 sda_low = 1'b0;
        #300;
    endtask
    // One 800 ns bit cell; a one releases the line so the device can answer
    task automatic put_bit(input logic b, output logic got);
        sda_low = ~b;
        #200 scl = 1'b1;
        #200 got = sda;
        #200 scl = 1'b0;
        #200;
    endtask
    // Eight bits MSB first, then the acknowledge slot
    task automatic xbyte(input logic [7:0] d, input logic a_out, output logic [7:0] q, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], q[i]);
        end
        put_bit(a_out, g);
        ack = ~g;
    endtask
endmodule

// *** tb/tb_mic_i2c_config_registers.sv ***
// Self-checking testbench of the microphone register block
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("unexpected at %0t: %0h not %0h", $time, g, e); end end
module tb_mic_i2c_config_registers
    import micr_pkg::*;
;
    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] wd;
        logic [4:0] req;
        logic [7:0] rexp;
        logic [4:0] gexp;
    } micr_row_t;
    localparam int WDT = 400;
    localparam micr_cfg_t CFG_EXP = '{1'b0, 2'h0, 2'h0, 2'h1, 2'h2, 5'h04, 1'b1, 5'h05, 3'h7};
    logic ref_clk = 1'b0, reset_n = 1'b0, channel_select_pin = 1'b0, acoustic_trigger = 1'b0;
    logic [4:0] loop_gain_request = 5'h10;
    logic       scl, host_low, sda, sda_out, sda_oe_n, wake_flag, trigger_rearm;
    logic [4:0] ambient_gain_code;
    micr_cfg_t  cfg;
    logic [6:0] dev;
    int         num_errors = 0, num_checks = 0, rearm_cnt = 0;
    logic [7:0] defs [7] = '{8'h00, 8'h10, 8'h0C, 8'h40, 8'h1B, 8'h07, 8'h00};
    micr_row_t  rows [11] = '{'{8'h00, 8'h08, 5'h10, 8'h00, 5'h10}, '{8'h02, 8'h0E, 5'h10, 8'h0E, 5'h10},
        '{8'h02, 8'hF1, 5'h10, 8'h01, 5'h10}, '{8'h03, 8'hFF, 5'h10, 8'h7F, 5'h1B},
        '{8'h04, 8'hE5, 5'h10, 8'h25, 5'h05}, '{8'h05, 8'hF8, 5'h10, 8'h00, 5'h05},
        '{8'h01, 8'hFF, 5'h03, 8'h05, 5'h05}, '{8'h03, 8'h44, 5'h03, 8'h44, 5'h04},
        '{8'h01, 8'h00, 5'h1E, 8'h05, 5'h05}, '{8'h06, 8'hAA, 5'h02, 8'h00, 5'h04},
        '{8'h05, 8'h07, 5'h04, 8'h07, 5'h04}};
    always #50 ref_clk = ~ref_clk;
    // Sole device on its own bus, pulled up when nobody drives
    assign sda = host_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);
    assign dev = 7'h60 | {6'h00, channel_select_pin};
    // Counted at the falling edge, away from the edge that launches the pulse
    always @(negedge ref_clk) if (trigger_rearm === 1'b1) rearm_cnt++;
    micr_regs #(.WDT_BASE_CYC(WDT)) uut (.ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .channel_select_pin(channel_select_pin),
        .loop_gain_request(loop_gain_request), .acoustic_trigger(acoustic_trigger), .wake_flag(wake_flag),
        .trigger_rearm(trigger_rearm), .ambient_gain_code(ambient_gain_code), .cfg(cfg));
    micr_host_model host (.scl(scl), .sda_low(host_low), .sda(sda));
    ////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (num_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Address byte, optional stall with SCL low, then a pointer byte
    task automatic probe(input logic [6:0] a, input int stall, output logic k1, output logic k2);
        logic [7:0] q;
        host.start;
        host.xbyte({a, 1'b0}, 1'b1, q, k1);
        repeat (stall) @(negedge ref_clk);
        host.xbyte(8'h00, 1'b1, q, k2);
        host.stop;
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        logic [7:0] q;
        logic k;
        host.start;
        host.xbyte({dev, 1'b0}, 1'b1, q, k);
        `CHK(k, 1'b1)
        host.xbyte(ptr, 1'b1, q, k);
        `CHK(k, 1'b1)
        host.xbyte(d, 1'b1, q, k);
        `CHK(k, 1'b1)
        host.stop;
    endtask
    // Pointer write, repeated start, one byte read and closed with a NACK
    task automatic rd(input logic [7:0] ptr, output logic [7:0] q);
        logic k;
        host.start;
        host.xbyte({dev, 1'b0}, 1'b1, q, k);
        host.xbyte(ptr, 1'b1, q, k);
        host.start;
        host.xbyte({dev, 1'b1}, 1'b1, q, k);
        host.xbyte(8'hFF, 1'b1, q, k);
        host.stop;
    endtask
    task automatic chk_defs;
        logic [7:0] q;
        for (int i = 0; i < 7; i++) begin
            rd(i[7:0], q);
            `CHK(q, defs[i])
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge ref_clk);
        num_errors++;
        end_sim;
    end
    initial begin
        logic [7:0] q;
        logic k1, k2;
        repeat (6) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk_defs;
        // Ordinary cases: write, read back, watch the gain readback
        foreach (rows[i]) begin
            @(negedge ref_clk) loop_gain_request = rows[i].req;
            wr(rows[i].ptr, rows[i].wd);
            rd(rows[i].ptr, q);
            `CHK(q, rows[i].rexp)
            `CHK(ambient_gain_code, rows[i].gexp)
        end
        `CHK(cfg, CFG_EXP)
        // Wake flag: readback leaves it alone, clear is a single pulse
        @(negedge ref_clk) acoustic_trigger = 1'b1;
        @(negedge ref_clk) acoustic_trigger = 1'b0;
        rd(8'h01, q);
        `CHK(wake_flag, 1'b1)
        wr(8'h00, 8'h10);
        `CHK(wake_flag, 1'b0)
        wr(8'h00, 8'h00);
        rd(8'h00, q);
        `CHK(q, 8'h00)
        `CHK(rearm_cnt, 1)
        // Both pin levels: own address answers, the other does not
        for (int c = 0; c < 2; c++) begin
            @(negedge ref_clk) channel_select_pin = c[0];
            probe(7'h60 | 7'(c), 0, k1, k2);
            `CHK(k1, 1'b1)
            probe(7'h61 - 7'(c), 0, k1, k2);
            `CHK(k1, 1'b0)
        end
        // Each timeout code: just over expires, a margin under survives
        for (int d = 3; d >= 0; d--) begin
            wr(8'h00, {5'h00, 2'(d), 1'b1});
            probe(dev, (WDT << d) + 50, k1, k2);
            `CHK(k2, 1'b0)
            probe(dev, (WDT << d) - 300, k1, k2);
            `CHK(k2, 1'b1)
        end
        wr(8'h00, 8'h00);
        probe(dev, 5000, k1, k2);
        `CHK(k2, 1'b1)
        rd(8'h05, q);
        `CHK(q, 8'h07)
        // Second reset in mid-run brings the defaults back
        @(negedge ref_clk) reset_n = 1'b0;
        loop_gain_request = 5'h10;
        repeat (6) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk_defs;
        end_sim;
    end
endmodule
